// >>> include/pwm_pkg.sv
/*
 Package for the auto-shutdown PWM generator: widths, reset values, states and the configuration struct.
 Assumes one synchronous clock domain and no register bus.
*/
package pwm_pkg;
    localparam int unsigned CNT_W      = 8;
    localparam logic [7:0]  CNT_ZERO   = 8'h00;
    localparam logic [7:0]  CNT_ONE    = 8'h01;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_TRIP,
        ST_LATCHED
    } sd_state_e;

    // Software-facing configuration
    typedef struct packed {
        logic             shutdown_en;
        logic             auto_restart;
        logic [CNT_W-1:0] period;
        logic [CNT_W-1:0] duty;
    } pwm_cfg_s;
endpackage

// >>> design/pwm_auto_shutdown.sv
/*
 Auto-shutdown PWM generator, the whole block in one module.
 Assumes shutdown_evt and the configuration inputs are synchronous to ref_clk.
*/
// Function
// - Shutdown acts only when function enabled
// - Event kills active pulse immediately
// - Event present at period start suppresses pulse
// - Resume only at a period boundary
// - Auto restart resumes without software
`timescale 1ns/1ps
module pwm_auto_shutdown
    import pwm_pkg::*;
(
    input  wire logic     ref_clk,
    input  wire logic     rst_n,
    input  wire logic     clk_en,
    input  wire pwm_cfg_s cfg,
    input  wire logic     shutdown_evt,
    input  wire logic     sd_flag_clr,
    output logic          pwm_out,
    output logic          sd_flag,
    output logic          period_start
);

    ////////////////////////////////////////////////////////////////////////
    // Period counter
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    wire              wrap = (cnt_q >= cfg.period);

    assign cnt_d        = wrap ? CNT_ZERO : cnt_q + CNT_ONE;
    assign period_start = clk_en && wrap;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= CNT_ZERO;
        end else if (clk_en) begin
            cnt_q <= cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shutdown state
    sd_state_e state_q;
    sd_state_e state_d;
    logic      flag_q;
    logic      flag_d;
    wire       evt = cfg.shutdown_en && shutdown_evt;

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_RUN: begin
                if (evt) begin
                    state_d = ST_TRIP;
                end
            end
            ST_TRIP: begin
                // Wait for boundary with event gone
                if (wrap && !evt) begin
                    state_d = cfg.auto_restart ? ST_RUN : ST_LATCHED;
                end
            end
            ST_LATCHED: begin
                if (evt) begin
                    state_d = ST_TRIP;
                end else if (wrap && !flag_q) begin
                    state_d = ST_RUN;
                end
            end
            default: begin
                state_d = ST_TRIP;
            end
        endcase
    end

    // Set wins over clear
    assign flag_d = evt ? 1'b1 : (sd_flag_clr ? 1'b0 : flag_q);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_RUN;
            flag_q  <= 1'b0;
        end else if (clk_en) begin
            state_q <= state_d;
            flag_q  <= flag_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output stage
    // Pulse window decode
    function automatic logic pulse_on(
        input logic [CNT_W-1:0] cnt,
        input logic [CNT_W-1:0] duty
    );
        return (cnt < duty);
    endfunction

    logic pwm_q;
    wire  run_next = (state_d == ST_RUN);
    wire  cmp_next = pulse_on(cnt_d, cfg.duty);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pwm_q <= 1'b0;
        end else if (clk_en) begin
            pwm_q <= run_next && cmp_next;
        end
    end

    // Combinational kill path for immediate cut-off
    assign pwm_out = pwm_q && !evt;
    assign sd_flag = flag_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    chk_evt_kills_out: assert property (@(posedge ref_clk) disable iff (!rst_n)
        evt |-> !pwm_out)
        else $error("pwm high during shutdown event");

    chk_disabled_ignores: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (clk_en && !cfg.shutdown_en && state_q == ST_RUN) |=> state_q == ST_RUN)
        else $error("shutdown acted while disabled");

    chk_no_mid_resume: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (clk_en && state_q != ST_RUN && !wrap) |=> state_q != ST_RUN)
        else $error("resumed in mid period");

    chk_suppress_start: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (clk_en && wrap && evt) |=> !pwm_q)
        else $error("pulse began with event present");

    chk_auto_restart: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (clk_en && state_q == ST_TRIP && wrap && !evt && cfg.auto_restart)
        |=> state_q == ST_RUN)
        else $error("auto restart did not resume");

    chk_latched_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (clk_en && state_q == ST_LATCHED && flag_q && !sd_flag_clr)
        |=> state_q != ST_RUN)
        else $error("resumed with flag set");

    chk_flag_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (clk_en && evt) |=> sd_flag)
        else $error("flag not set by event");

    chk_trip_entry: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (clk_en && evt) |=> (state_q == ST_TRIP && !pwm_q))
        else $error("event did not trip");

    chk_flag_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (clk_en && !evt && sd_flag_clr) |=> !sd_flag)
        else $error("flag not cleared");

    chk_flag_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (clk_en && !evt && !sd_flag_clr && sd_flag) |=> sd_flag)
        else $error("flag dropped by itself");

    chk_freeze_cnt: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !clk_en |=> (cnt_q == $past(cnt_q)))
        else $error("counter moved while frozen");

    chk_freeze_state: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !clk_en |=> (state_q == $past(state_q) && flag_q == $past(flag_q)))
        else $error("state moved while frozen");

    chk_cnt_wrap: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (clk_en && wrap) |=> (cnt_q == CNT_ZERO))
        else $error("counter did not wrap");

    chk_cnt_step: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (clk_en && !wrap) |=> (cnt_q == $past(cnt_q) + CNT_ONE))
        else $error("counter did not step");

    chk_latched_resume: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (clk_en && state_q == ST_LATCHED && wrap && !evt && !flag_q)
        |=> state_q == ST_RUN)
        else $error("latched did not resume");

    chk_manual_latch: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (clk_en && state_q == ST_TRIP && wrap && !evt && !cfg.auto_restart)
        |=> state_q == ST_LATCHED)
        else $error("manual mode did not latch");

    chk_trip_waits: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (clk_en && state_q == ST_TRIP && evt) |=> state_q == ST_TRIP)
        else $error("left trip with event present");

    chk_idle_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state_q != ST_RUN) |-> !pwm_out)
        else $error("pwm high while shut down");

    chk_run_shape: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (clk_en && state_d == ST_RUN) |=> (pwm_q == $past(cmp_next)))
        else $error("pulse shape wrong in run");

    chk_disabled_pass: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !cfg.shutdown_en |-> (pwm_out == pwm_q))
        else $error("output cut while disabled");

    chk_latched_evt: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (clk_en && state_q == ST_LATCHED && evt) |=> state_q == ST_TRIP)
        else $error("new event ignored in latched");

    chk_run_stays: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (clk_en && state_q == ST_RUN && !evt) |=> state_q == ST_RUN)
        else $error("left run without event");

endmodule

// >>> test/shutdown_source_model.sv
/* Comparator model: trips one clock after the bench asks for it.
   Assumes requests come synchronous to ref_clk. */
`timescale 1ns/1ps
module shutdown_source_model (
    input  wire logic ref_clk,
    input  wire logic trip,
    output logic      shutdown_evt = 1'b0
);
    always @(posedge ref_clk) begin
        shutdown_evt <= trip;
    end
endmodule

// >>> test/test_pwm_auto_shutdown.sv
/* Self-checking bench for the auto-shutdown PWM generator.
   Assumes the comparator model and period 5, duty 3. */
`timescale 1ns/1ps
module test_pwm_auto_shutdown;
    import pwm_pkg::*;
    logic     ref_clk = 1'b0;
    logic     rst_n   = 1'b0;
    logic     clk_en  = 1'b1;
    pwm_cfg_s cfg     = '{1'b0, 1'b1, 8'h05, 8'h03};
    logic     trip    = 1'b0;
    logic     clr     = 1'b0;
    logic     evt, pwm_out, sd_flag, period_start;
    int       error_cnt = 0;
    int       check_count = 0;
    always #20 ref_clk = ~ref_clk;
    pwm_auto_shutdown u_pwm_auto_shutdown (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
        .cfg(cfg), .shutdown_evt(evt), .sd_flag_clr(clr), .pwm_out(pwm_out),
        .sd_flag(sd_flag), .period_start(period_start));
    shutdown_source_model u_shutdown_source_model (.ref_clk(ref_clk), .trip(trip),
        .shutdown_evt(evt));
    task automatic chk(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %b expected %b", $time, got, exp);
        end
    endtask
    task automatic trip_in_pulse();
        for (int i = 0; i < 20 && pwm_out !== 1'b1; i++) @(negedge ref_clk);
        @(posedge ref_clk) trip <= 1'b1;
        @(posedge ref_clk) #1;
        chk(pwm_out, 1'b0);
        repeat (14) @(negedge ref_clk) chk(pwm_out, 1'b0);
        @(posedge ref_clk) trip <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic resume();
        for (int i = 0; i < 20; i++) begin
            @(negedge ref_clk);
            if (period_start === 1'b1) break;
            chk(pwm_out, 1'b0);
        end
        @(negedge ref_clk) chk(pwm_out, 1'b1);
    endtask
    task automatic t_ignore();
        @(posedge ref_clk) trip <= 1'b1;
        repeat (2) @(negedge ref_clk);
        for (int i = 0; i < 20 && period_start !== 1'b1; i++) @(negedge ref_clk);
        repeat (3) @(negedge ref_clk) chk(pwm_out, 1'b1);
        @(negedge ref_clk) chk(pwm_out, 1'b0);
        chk(sd_flag, 1'b0);
        @(posedge ref_clk) trip <= 1'b0;
        @(posedge ref_clk);
        $display("test ignore done");
    endtask
    task automatic t_auto();
        @(posedge ref_clk) cfg.shutdown_en <= 1'b1;
        trip_in_pulse();
        resume();
        $display("test auto restart done");
    endtask
    task automatic t_latched();
        @(posedge ref_clk) cfg.auto_restart <= 1'b0;
        clr <= 1'b1;
        @(posedge ref_clk) clr <= 1'b0;
        trip_in_pulse();
        repeat (14) @(negedge ref_clk) chk(pwm_out, 1'b0);
        chk(sd_flag, 1'b1);
        @(posedge ref_clk) clr <= 1'b1;
        @(posedge ref_clk) clr <= 1'b0;
        @(negedge ref_clk) chk(sd_flag, 1'b0);
        resume();
        $display("test latched done");
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_ignore();
        t_auto();
        t_latched();
        end_sim();
    end
    initial begin
        #20000;
        error_cnt++;
        end_sim();
    end
endmodule
